// ===== cct_timing.sv
// Purpose: cache cycle time-state controller with memory bus launch
// Assumes: hit, write and requester flags arrive from same-clock logic
// Notes:   falling edge of sys_clk stands for the arbitration clock edge
`timescale 1ns/1ps
module cct_timing
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        line_power_low_n,
    input  wire logic        supply_power_low_n,
    input  wire logic        cycle_request,
    input  wire logic        cycle_is_write,
    input  wire logic        cycle_is_processor,
    input  wire logic        cycle_is_disk,
    input  wire logic        cache_hit,
    input  wire logic        control_ok,
    input  wire logic [21:2] cycle_address,
    input  wire logic [3:0]  cycle_byte_mask,
    input  wire logic [1:0]  cycle_op_code,
    input  wire logic [7:0]  cycle_index,
    input  wire logic        bus_data_occupied,
    input  wire logic        memory_addr_ack,
    input  wire logic        memory_data_ready,
    output logic             cycle_lock,
    output logic             first_time_state,
    output logic             second_time_state,
    output logic             third_time_state,
    output logic             fourth_time_state,
    output logic             hold_time_state,
    output logic             slow_cycle_request,
    output logic             cycle_done,
    output logic             memory_sync_acknowledge,
    output logic             write_data_launch,
    output logic             write_data_gate,
    output logic             memory_start,
    output logic [21:2]      main_address,
    output logic [3:0]       main_byte_mask,
    output logic [1:0]       memory_operation_code,
    output logic             main_address_parity,
    output logic             await_memory_response,
    output logic             tag_write_pulse,
    output logic             slow_sync_flag,
    output logic             relaunch_flag,
    output logic             powerup_active_flag,
    output logic             address_mux_select_0,
    output logic [7:0]       store_index,
    output logic             valid_input,
    output logic [1:0]       group_write_select,
    output logic [3:0]       data_chip_select,
    output logic             write_data_all_ones,
    output logic             store_write_pulse
);
    cct_pkg::cct_state_t             state_r;
    cct_pkg::cct_state_t             state_nxt;
    logic [cct_pkg::DESKEW_W-1:0]    deskew_r;
    logic                            deskew_done;
    logic                            resp_ok;
    logic [1:0]                      resp_sync_r;
    logic [cct_pkg::PUP_IDX_W-1:0]   pup_index;
    logic                            pup_pulse;
    logic                            hold_entry;
    logic                            ctl_seen_r;
    logic                            hold_d_r;
    logic                            await_d_r;

    // ================================
    // power-up sequencer
    cct_powerup u_powerup
    (
        .sys_clk             (sys_clk),
        .arst_n              (arst_n),
        .line_power_low_n    (line_power_low_n),
        .supply_power_low_n  (supply_power_low_n),
        .powerup_active_flag (powerup_active_flag),
        .pup_index           (pup_index),
        .pup_write_pulse     (pup_pulse)
    );

    // ================================
    // time-state sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            cct_pkg::CCT_IDLE:
                if (cycle_request && !powerup_active_flag)
                    state_nxt = cct_pkg::CCT_FIRST;
            cct_pkg::CCT_FIRST:  state_nxt = cct_pkg::CCT_SECOND;
            cct_pkg::CCT_SECOND: state_nxt = cct_pkg::CCT_THIRD;
            cct_pkg::CCT_THIRD:  state_nxt = cct_pkg::CCT_FOURTH;
            cct_pkg::CCT_FOURTH: state_nxt = cct_pkg::CCT_HOLD;
            cct_pkg::CCT_HOLD:
                if (cache_hit && !cycle_is_write)
                begin
                    if (!cycle_is_processor || control_ok || ctl_seen_r)
                        state_nxt = cct_pkg::CCT_DONE;
                end
                else if (!cycle_is_processor || control_ok || ctl_seen_r)
                    state_nxt = cct_pkg::CCT_SLOW;
            cct_pkg::CCT_SLOW:
                if (relaunch_flag)
                    state_nxt = cct_pkg::CCT_DONE;
            cct_pkg::CCT_DONE:   state_nxt = cct_pkg::CCT_IDLE;
            default:             state_nxt = cct_pkg::CCT_IDLE;
        endcase
    end

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= cct_pkg::CCT_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctl_seen_r <= 1'b0;
        else if (state_r == cct_pkg::CCT_IDLE)
            ctl_seen_r <= 1'b0;
        else if (control_ok)
            ctl_seen_r <= 1'b1;
    end

    // lock held from first state until done; second start is blocked
    assign cycle_lock        = (state_r != cct_pkg::CCT_IDLE) &&
                               (state_r != cct_pkg::CCT_DONE);
    assign first_time_state  = (state_r == cct_pkg::CCT_FIRST) ||
                               (state_r == cct_pkg::CCT_SECOND);
    assign second_time_state = (state_r == cct_pkg::CCT_SECOND) ||
                               (state_r == cct_pkg::CCT_THIRD);
    assign third_time_state  = (state_r == cct_pkg::CCT_THIRD);
    assign fourth_time_state = (state_r == cct_pkg::CCT_FOURTH);
    assign hold_time_state   = (state_r == cct_pkg::CCT_HOLD);
    assign slow_cycle_request = (state_r == cct_pkg::CCT_SLOW);
    assign cycle_done        = (state_r == cct_pkg::CCT_DONE);
    assign hold_entry        = hold_time_state && !hold_d_r;

    // ================================
    // previous hold, marks the first hold cycle
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_d_r <= 1'b0;
        else
            hold_d_r <= hold_time_state;
    end

    // ================================
    // processor acknowledge
    always_comb
    begin
        memory_sync_acknowledge = 1'b0;
        if (cycle_is_processor && hold_time_state && cache_hit &&
            !cycle_is_write && (control_ok || ctl_seen_r))
            memory_sync_acknowledge = 1'b1;
        else if (cycle_is_processor && slow_sync_flag)
            memory_sync_acknowledge = 1'b1;
    end

    // ================================
    // address and control onto main bus
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_address          <= '0;
            main_byte_mask        <= 4'h0;
            memory_operation_code <= 2'h0;
            main_address_parity   <= 1'b0;
        end
        else if (state_r == cct_pkg::CCT_IDLE && state_nxt ==
                 cct_pkg::CCT_FIRST)
        begin
            main_address          <= cycle_address;
            main_byte_mask        <= cycle_byte_mask;
            memory_operation_code <= cycle_op_code;
            main_address_parity   <= ~^{cycle_address, cycle_byte_mask,
                                        cycle_op_code};
        end
    end

    // ================================
    // write launch, deskew and start strobe
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            write_data_launch <= 1'b0;
        else if (!cycle_lock)
            write_data_launch <= 1'b0;
        else if (!cycle_is_write)
            write_data_launch <= 1'b1;
        else if (slow_cycle_request && !bus_data_occupied)
            write_data_launch <= 1'b1;
    end
    assign write_data_gate = write_data_launch && cycle_is_write;

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            deskew_r <= '0;
        else if (!(slow_cycle_request && write_data_launch))
            deskew_r <= '0;
        else if (!deskew_done)
            deskew_r <= deskew_r + 1'b1;
    end
    assign deskew_done = (deskew_r ==
                          cct_pkg::DESKEW_W'(cct_pkg::DESKEW_CYC));

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            memory_start <= 1'b0;
        else if (memory_addr_ack || !slow_cycle_request)
            memory_start <= 1'b0;
        else if (deskew_r == cct_pkg::DESKEW_W'(cct_pkg::DESKEW_CYC - 1) &&
                 write_data_launch)
            memory_start <= 1'b1;
    end

    // ================================
    // memory response and restart
    assign resp_ok = memory_addr_ack &&
                     (cycle_is_write || cycle_is_disk ||
                      memory_data_ready);

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            await_memory_response <= 1'b0;
        else if (!slow_cycle_request)
            await_memory_response <= 1'b0;
        else if (memory_start)
            await_memory_response <= 1'b1;
        else if (await_memory_response && resp_ok)
            await_memory_response <= 1'b0;
    end

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            await_d_r <= 1'b0;
        else
            await_d_r <= await_memory_response;
    end

    // wait just ended: one pulse per memory cycle
    assign tag_write_pulse = await_d_r && !await_memory_response &&
                             slow_cycle_request;

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            resp_sync_r <= 2'h0;
        else if (!slow_cycle_request)
            resp_sync_r <= 2'h0;
        else
            resp_sync_r <= {resp_sync_r[0], tag_write_pulse};
    end
    assign slow_sync_flag = resp_sync_r[0];
    assign relaunch_flag  = resp_sync_r[1];

    // ================================
    // store controls, power-up overrides
    assign address_mux_select_0 = powerup_active_flag;
    assign store_index        = powerup_active_flag ? pup_index :
                                cycle_index;
    assign valid_input        = !powerup_active_flag;
    assign group_write_select = powerup_active_flag ? 2'h3 : 2'h0;
    assign data_chip_select   = powerup_active_flag ? 4'hf : 4'h0;
    assign write_data_all_ones = powerup_active_flag;
    assign store_write_pulse  = pup_pulse;

    // ================================
    // checks
    a_seq_order :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        state_r == cct_pkg::CCT_FIRST |=> second_time_state ##1
        third_time_state && !first_time_state ##1
        fourth_time_state && !second_time_state ##1
        hold_time_state && !fourth_time_state)
    else $error("time states out of order");

    a_single_start :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        cycle_lock && !first_time_state |=> !(state_r == cct_pkg::CCT_FIRST))
    else $error("second sequence started in one cycle");

    a_hit_done :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        hold_time_state && cache_hit && !cycle_is_write &&
        (!cycle_is_processor || control_ok || ctl_seen_r)
        |=> cycle_done ##1 !cycle_lock)
    else $error("read hit did not finish");

    a_sync_at_hold :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        hold_entry && cycle_is_processor && cache_hit && !cycle_is_write &&
        control_ok |-> memory_sync_acknowledge)
    else $error("sync acknowledge missing at hold start");

    a_start_deskew :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        $rose(memory_start) |-> $past(slow_cycle_request, 10) &&
        $past(write_data_launch, 10))
    else $error("start strobe before deskew");

    a_launch_free :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        $rose(write_data_launch) && cycle_is_write |->
        !$past(bus_data_occupied))
    else $error("write launched while bus occupied");

    a_ack_drop :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        memory_start && memory_addr_ack |=> !memory_start)
    else $error("start strobe held after acknowledge");

    a_wait_end :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        await_memory_response && !memory_start && memory_addr_ack &&
        (cycle_is_write || cycle_is_disk || memory_data_ready)
        |=> !await_memory_response)
    else $error("memory wait did not end");

    a_wait_hold :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        await_memory_response && slow_cycle_request && !memory_addr_ack
        |=> await_memory_response)
    else $error("memory wait ended without acknowledge");

    a_relaunch_done :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        tag_write_pulse |-> ##1 slow_sync_flag ##1 relaunch_flag ##1
        cycle_done)
    else $error("restart chain broken");

    a_pup_selects :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        powerup_active_flag |-> data_chip_select == 4'hf && !valid_input &&
        !cycle_lock)
    else $error("power-up controls wrong");
endmodule

// ===== cct_pkg.sv
// Purpose: constants and types for the cache cycle timing controller
// Assumes: one 100 MHz clock, sys_clk, with its falling edge as active edge
// Notes:   offsets, counts, state codes and the power-up index reset value live here
package cct_pkg;
    localparam int    CLK_MHZ        = 100;
    localparam int    DESKEW_NS      = 100;
    localparam int    DESKEW_CYC     = (DESKEW_NS * CLK_MHZ + 999) / 1000;
    localparam int    DESKEW_W       = 4;
    localparam int    PUP_IDX_W      = 8;
    localparam int    ADDR_HI        = 21;
    localparam int    ADDR_LO        = 2;
    localparam int    PUP_OSC_DIV    = 4;
    localparam int    PUP_OSC_W      = 2;
    localparam logic [7:0] PUP_IDX_RST = 8'h00;
    localparam logic [7:0] PUP_IDX_LAST = 8'hff;

    typedef enum logic [2:0]
    {
        CCT_IDLE   = 3'b000,
        CCT_FIRST  = 3'b001,
        CCT_SECOND = 3'b010,
        CCT_THIRD  = 3'b011,
        CCT_FOURTH = 3'b100,
        CCT_HOLD   = 3'b101,
        CCT_SLOW   = 3'b110,
        CCT_DONE   = 3'b111
    } cct_state_t;
endpackage

// ===== cct_powerup.sv
// Purpose: power-up invalidation sequencer
// Assumes: power levels arrive raw and are synchronised here
// Notes:   runs the same way after a brief power failure
`timescale 1ns/1ps
module cct_powerup
(
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic                  line_power_low_n,
    input  wire logic                  supply_power_low_n,
    output logic                       powerup_active_flag,
    output logic [cct_pkg::PUP_IDX_W-1:0] pup_index,
    output logic                       pup_write_pulse
);
    logic [1:0]                    line_sync_r;
    logic [1:0]                    supply_sync_r;
    logic                          line_low;
    logic                          supply_low;
    logic [cct_pkg::PUP_OSC_W-1:0] osc_r;
    logic                          tick;

    // ================================
    // power level synchronisers
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_sync_r   <= 2'h0;
            supply_sync_r <= 2'h0;
        end
        else
        begin
            line_sync_r   <= {line_sync_r[0], line_power_low_n};
            supply_sync_r <= {supply_sync_r[0], supply_power_low_n};
        end
    end
    assign line_low   = !line_sync_r[1];
    assign supply_low = !supply_sync_r[1];

    // ================================
    // pulse oscillator, free only when line power is good
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            osc_r <= '0;
        else if (line_low || !powerup_active_flag)
            osc_r <= '0;
        else
            osc_r <= osc_r + 1'b1;
    end
    assign tick = (osc_r == cct_pkg::PUP_OSC_W'(cct_pkg::PUP_OSC_DIV - 1));
    assign pup_write_pulse = tick && powerup_active_flag && !line_low;

    // ================================
    // index counter and flag
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            pup_index <= cct_pkg::PUP_IDX_RST;
        else if (line_low)
            pup_index <= cct_pkg::PUP_IDX_RST;
        else if (pup_write_pulse)
            pup_index <= pup_index + 1'b1;
    end

    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            powerup_active_flag <= 1'b1;
        else if (supply_low)
            powerup_active_flag <= 1'b1;
        else if (pup_write_pulse && pup_index == cct_pkg::PUP_IDX_LAST)
            powerup_active_flag <= 1'b0;
    end

    a_pup_overflow_clear :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        pup_write_pulse && pup_index == cct_pkg::PUP_IDX_LAST && !supply_low
        |=> !powerup_active_flag)
    else $error("power-up flag not cleared at overflow");

    a_pup_index_step :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        pup_write_pulse && !line_low |=> pup_index == $past(pup_index) + 8'h01)
    else $error("power-up index did not step");

    a_pup_line_clear :
    assert property (@(negedge sys_clk) disable iff (!arst_n)
        line_low |=> pup_index == 8'h00)
    else $error("index not cleared on line power low");
endmodule

// ===== cct_mem_model.sv
// Purpose: main memory bus responder for the timing bench
// Assumes: falling edge of sys_clk is the active edge
// Notes:   ack delay and data ready need set by the bench
`timescale 1ns/1ps
module cct_mem_model
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       memory_start,
    input  wire logic       await_memory_response,
    input  wire logic [3:0] ack_delay,
    input  wire logic       need_ready,
    output logic            memory_addr_ack,
    output logic            memory_data_ready
);
    logic [3:0] wait_r;
    // ====
    // address ack, held while strobe stands
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_r          <= 4'h0;
            memory_addr_ack <= 1'b0;
        end
        else if (memory_start && !memory_addr_ack)
        begin
            wait_r          <= wait_r + 4'h1;
            memory_addr_ack <= (wait_r >= ack_delay);
        end
        else
        begin
            wait_r          <= 4'h0;
            memory_addr_ack <= memory_start;
        end
    end
    // ====
    // data ready after ack, dropped once the wait ends
    always_ff @(negedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            memory_data_ready <= 1'b0;
        else
            memory_data_ready <= need_ready && await_memory_response
                && (memory_addr_ack || memory_data_ready);
    end
endmodule

// ===== test_cct_timing.sv
// Purpose: self-checking bench for the cache cycle timing controller
// Assumes: inputs change on falling edge, outputs sampled on rising
// Notes:   events logged as cycle numbers in t, counts in n
`timescale 1ns/1ps
module test_cct_timing;
    logic        sys_clk, arst_n = 1'b0, need_ready = 1'b0;
    logic        line_power_low_n = 1'b1, supply_power_low_n = 1'b1;
    logic        cycle_request = 1'b0, cycle_is_write = 1'b0;
    logic        cycle_is_processor = 1'b0, cycle_is_disk = 1'b0;
    logic        cache_hit = 1'b0, control_ok = 1'b0;
    logic        bus_data_occupied = 1'b0, memory_addr_ack;
    logic [21:2] cycle_address = 20'h00000, main_address;
    logic [3:0]  cycle_byte_mask = 4'h0, ack_delay = 4'h0;
    logic [1:0]  cycle_op_code = 2'h0, memory_operation_code;
    logic [7:0]  cycle_index = 8'h00, store_index;
    logic [3:0]  main_byte_mask, data_chip_select;
    logic [1:0]  group_write_select;
    logic        memory_data_ready, cycle_lock, first_time_state;
    logic        second_time_state, third_time_state, fourth_time_state;
    logic        hold_time_state, slow_cycle_request, cycle_done;
    logic        memory_sync_acknowledge, write_data_launch;
    logic        write_data_gate, memory_start, main_address_parity;
    logic        await_memory_response, tag_write_pulse, slow_sync_flag;
    logic        relaunch_flag, powerup_active_flag, address_mux_select_0;
    logic        valid_input, write_data_all_ones, store_write_pulse;
    int          failures = 0, compares = 0;
    int          t[15];
    int          n[5];

    cct_timing dut_u
    (
        .sys_clk, .arst_n, .line_power_low_n, .supply_power_low_n,
        .cycle_request, .cycle_is_write, .cycle_is_processor,
        .cycle_is_disk, .cache_hit, .control_ok, .cycle_address,
        .cycle_byte_mask, .cycle_op_code, .cycle_index,
        .bus_data_occupied, .memory_addr_ack, .memory_data_ready,
        .cycle_lock, .first_time_state, .second_time_state,
        .third_time_state, .fourth_time_state, .hold_time_state,
        .slow_cycle_request, .cycle_done, .memory_sync_acknowledge,
        .write_data_launch, .write_data_gate, .memory_start,
        .main_address, .main_byte_mask, .memory_operation_code,
        .main_address_parity, .await_memory_response, .tag_write_pulse,
        .slow_sync_flag, .relaunch_flag, .powerup_active_flag,
        .address_mux_select_0, .store_index, .valid_input,
        .group_write_select, .data_chip_select, .write_data_all_ones,
        .store_write_pulse
    );
    cct_mem_model mem_u
    (
        .sys_clk, .arst_n, .memory_start, .await_memory_response,
        .ack_delay, .need_ready, .memory_addr_ack, .memory_data_ready
    );

    // ====
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic run_powerup();
        int k;
        k = 0;
        @(posedge sys_clk);
        check("pup flag", 1, powerup_active_flag);
        check("valid in", 0, valid_input);
        check("selects", 6'h3f,
              {group_write_select, data_chip_select});
        check("ones amx", 2'h3,
              {write_data_all_ones, address_mux_select_0});
        for (int g = 0; g < 1500 && powerup_active_flag === 1'b1; g++)
        begin
            if (store_write_pulse === 1'b1)
            begin
                check("pup index", k, store_index);
                k++;
            end
            @(posedge sys_clk);
        end
        check("pup pulses", 256, k);
        check("pup end", 0, powerup_active_flag);
        check("run ctl", 4'h8, {valid_input, write_data_all_ones,
              address_mux_select_0, |{group_write_select,
              data_chip_select}});
    endtask

    task automatic run_cycle(input logic wr, pr, dk, ht, input int ctl,
                             input int occ, input logic [21:2] adr);
        logic [14:0] s;
        logic        prev;
        prev = 1'b0;
        t = '{default: -1};
        n = '{default: 0};
        @(negedge sys_clk);
        cycle_is_write <= wr;
        cycle_is_processor <= pr;
        cycle_is_disk <= dk;
        cache_hit <= ht;
        cycle_address <= adr;
        cycle_byte_mask <= adr[5:2];
        cycle_op_code <= adr[3:2];
        cycle_index <= adr[9:2];
        control_ok <= (ctl == 0);
        bus_data_occupied <= (occ > 0);
        cycle_request <= 1'b1;
        for (int c = 0; c < 400 && t[5] < 0; c++)
        begin
            @(posedge sys_clk);
            s = {relaunch_flag, slow_sync_flag, tag_write_pulse,
                 memory_data_ready, memory_addr_ack, memory_start,
                 write_data_launch, slow_cycle_request,
                 memory_sync_acknowledge, cycle_done, hold_time_state,
                 fourth_time_state, third_time_state, second_time_state,
                 first_time_state};
            for (int i = 0; i < 15; i++)
                if (s[i] === 1'b1 && t[i] < 0)
                    t[i] = c;
            if (t[4] == c)
                check("bus", {adr, adr[5:2], adr[3:2]}, {main_address,
                      main_byte_mask, memory_operation_code});
            if (t[4] == c)
                check("parity", 1, ^{main_address, main_byte_mask,
                      memory_operation_code, main_address_parity});
            if (t[4] == c)
                check("index", adr[9:2], store_index);
            n[0] += (s[0] === 1'b1 && !prev);
            prev = (s[0] === 1'b1);
            n[1] += (wr && bus_data_occupied && s[8] === 1'b1);
            n[2] += (wr && write_data_gate !== s[8]);
            n[3] += (s[9] === 1'b1 && s[10] === 1'b1);
            n[4] += (s[12] === 1'b1);
            @(negedge sys_clk);
            bus_data_occupied <= (c + 1 < occ);
            if (c + 1 == ctl)
                control_ok <= 1'b1;
        end
        cycle_request <= 1'b0;
        control_ok <= 1'b0;
        check("starts", 1, n[0]);
        check("second", t[0] + 1, t[1]);
        check("third", t[0] + 2, t[2]);
        check("fourth", t[0] + 3, t[3]);
        check("hold", t[0] + 4, t[4]);
        repeat (2) @(posedge sys_clk);
        check("idle", 0, {cycle_lock, hold_time_state, first_time_state,
              await_memory_response});
    endtask

    // ====
    // scenarios
    task automatic t_read_hit();
        run_cycle(1'b0, 1'b1, 1'b0, 1'b1, 0, 0, 20'h12345);
        check("sync at hold", t[4], t[6]);
        check("hit done", t[4] + 1, t[5]);
        check("no slow", -1, t[7]);
    endtask

    task automatic t_late_ctl();
        run_cycle(1'b0, 1'b1, 1'b0, 1'b1, 12, 0, 20'habcde);
        check("late sync", 12, t[6]);
        check("held done", 13, t[5]);
    endtask

    task automatic t_read_miss();
        int go;
        need_ready = 1'b1;
        ack_delay = 4'h4;
        run_cycle(1'b0, 1'b1, 1'b0, 1'b0, 0, 0, 20'h0f0f0);
        go = (t[8] > t[7]) ? t[8] : t[7];
        check("slow", t[4] + 1, t[7]);
        check("launch early", 1, t[8] <= t[7]);
        check("rd deskew", cct_pkg::DESKEW_CYC, t[9] - go);
        check("start drop", 1, n[3] inside {[1:2]});
        check("tag late", 1, t[12] > t[11] && t[11] >= 0);
        check("tag once", 1, n[4]);
        check("slow sync", t[12] + 1, t[13]);
        check("relaunch", t[12] + 2, t[14]);
        check("miss done", t[12] + 3, t[5]);
        check("miss sync", t[13], t[6]);
    endtask

    task automatic t_write_busy();
        need_ready = 1'b0;
        ack_delay = 4'h0;
        run_cycle(1'b1, 1'b1, 1'b0, 1'b1, 0, 12, 20'h2aaaa);
        check("launch busy", 0, n[1]);
        check("gate", 0, n[2]);
        check("launch wait", 1, t[8] >= 12);
        check("wr deskew", cct_pkg::DESKEW_CYC, t[9] - t[8]);
        check("ack end", 1, t[12] >= 0 && t[11] < 0);
        check("wr sync", t[13], t[6]);
    endtask

    task automatic t_disk_read();
        ack_delay = 4'h2;
        run_cycle(1'b0, 1'b0, 1'b1, 1'b0, 0, 0, 20'h3c3c3);
        check("disk tag", 1, n[4]);
        check("disk done", t[12] + 3, t[5]);
        check("no sync", -1, t[6]);
    endtask

    task automatic t_power_dip();
        @(negedge sys_clk);
        line_power_low_n <= 1'b0;
        supply_power_low_n <= 1'b0;
        repeat (4) @(negedge sys_clk);
        line_power_low_n <= 1'b1;
        supply_power_low_n <= 1'b1;
        run_powerup();
    endtask

    // ====
    // clock, watchdog, sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #100_000;
        failures++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(negedge sys_clk);
        arst_n <= 1'b1;
        run_powerup();
        t_read_hit();
        t_late_ctl();
        t_read_miss();
        t_write_busy();
        t_disk_read();
        t_power_dip();
        t_read_hit();
        stop_test();
    end
endmodule
